// [hdlc_buf_pkg.sv]
package hdlc_buf_pkg;
   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 8;
   localparam int unsigned IDX_WIDTH = 7;
   localparam int unsigned SEL_WIDTH = 2;
   localparam int unsigned SLOT_WIDTH = 3;
   localparam int unsigned MEM_AWIDTH = 10;
   localparam int unsigned BUFS_PER_CTRL = 2;
   localparam int unsigned DEF_BUF_DEPTH = 96;
   localparam int unsigned DEF_NUM_CTRL = 3;
   // per-channel offsets within the channel's register window
   localparam logic [11:0] SEL_OFFSET = 12'h11b;
   localparam logic [11:0] BUF0_OFFSET = 12'h600;
   localparam logic [11:0] BUF1_OFFSET = 12'h700;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// [hdlc_message_buffer_port.sv]
`timescale 1ns/1ns
module hdlc_message_buffer_port
   import hdlc_buf_pkg::*;
#(
   parameter int unsigned NUM_CTRL = DEF_NUM_CTRL,
   parameter int unsigned BUF_DEPTH = DEF_BUF_DEPTH
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [ADDR_WIDTH-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [DATA_WIDTH-1:0] bus_wdata,
   output logic [DATA_WIDTH-1:0] bus_rdata,
   output logic bus_rvalid,
   input wire logic [NUM_CTRL-1:0] tx_free_buffer_flag,
   input wire logic [NUM_CTRL-1:0] rx_filled_buffer_indicator,
   input wire logic [NUM_CTRL-1:0] rx_done,
   output logic [NUM_CTRL-1:0] rx_transfer_done_irq,
   output logic tx_load_strobe,
   output logic [SEL_WIDTH-1:0] tx_load_ctrl,
   output logic tx_load_buf,
   output logic [IDX_WIDTH-1:0] tx_load_len,
   input wire logic eng_we,
   input wire logic [SEL_WIDTH-1:0] eng_ctrl,
   input wire logic eng_buf,
   input wire logic [IDX_WIDTH-1:0] eng_idx,
   input wire logic [DATA_WIDTH-1:0] eng_wdata,
   output logic [DATA_WIDTH-1:0] eng_rdata
);

   localparam int unsigned NUM_SLOT = NUM_CTRL * BUFS_PER_CTRL;
   localparam int unsigned MEM_DEPTH = NUM_SLOT * BUF_DEPTH;
   localparam logic [IDX_WIDTH-1:0] IDX_LAST = IDX_WIDTH'(BUF_DEPTH - 1);

   // select is two bits and the index seven, hence the upper bounds
   if (NUM_CTRL < 1 || NUM_CTRL > 4 || BUF_DEPTH < 2 || BUF_DEPTH > 127)
   begin : g_bad_params
      $error("hdlc_message_buffer_port: unsupported parameters");
   end

   function automatic logic [MEM_AWIDTH-1:0] mem_addr(
      input logic [SLOT_WIDTH-1:0] slot,
      input logic [IDX_WIDTH-1:0] idx);
      mem_addr = MEM_AWIDTH'(slot) * MEM_AWIDTH'(BUF_DEPTH)
         + MEM_AWIDTH'(idx);
   endfunction

   logic [DATA_WIDTH-1:0] buf_mem [MEM_DEPTH];
   logic [IDX_WIDTH-1:0] idx_reg [NUM_SLOT];
   logic [SEL_WIDTH-1:0] sel_reg;
   logic [NUM_CTRL-1:0] tx_flag_prev_reg;
   logic [NUM_SLOT-1:0] restart;

   logic hit_buf0, hit_buf1, hit_sel, port_hit, host_buf;
   logic writable, readable, wr_take, port_acc;
   logic [SLOT_WIDTH-1:0] host_slot;
   logic [IDX_WIDTH-1:0] host_idx;

   assign hit_buf0 = (bus_addr == BUF0_OFFSET);
   assign hit_buf1 = (bus_addr == BUF1_OFFSET);
   assign hit_sel = (bus_addr == SEL_OFFSET);
   assign port_hit = hit_buf0 | hit_buf1;
   assign host_buf = hit_buf1;
   // slot number is controller*2+buffer, i.e. a plain concatenation
   assign host_slot = {1'b0, sel_reg} << 1 | SLOT_WIDTH'(host_buf);
   assign host_idx = idx_reg[host_slot];
   // only the buffer flagged free takes transmit data
   assign writable = (host_buf == tx_free_buffer_flag[sel_reg]);
   assign readable = (host_buf == rx_filled_buffer_indicator[sel_reg]);
   assign wr_take = bus_wr & port_hit & writable;
   assign port_acc = port_hit & (bus_wr | bus_rd);

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sel_reg <= SEL_RESET;
      // a select beyond the last controller is ignored
      else if (bus_wr && hit_sel && bus_wdata < DATA_WIDTH'(NUM_CTRL))
         sel_reg <= bus_wdata[SEL_WIDTH-1:0];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         tx_flag_prev_reg <= '0;
      else
         tx_flag_prev_reg <= tx_free_buffer_flag;
   end

   always_comb
   begin
      restart = '0;
      for (int c = 0; c < NUM_CTRL; c++)
      begin
         if (tx_free_buffer_flag[c] != tx_flag_prev_reg[c])
            restart[2 * c + int'(tx_free_buffer_flag[c])] = 1'b1;
         if (rx_done[c])
            restart[2 * c + int'(rx_filled_buffer_indicator[c])] = 1'b1;
      end
   end

   // a restart wins over a host step in the same cycle
   always_ff @(posedge clock)
   begin
      for (int s = 0; s < NUM_SLOT; s++)
      begin
         if (sys_rst || restart[s])
            idx_reg[s] <= '0;
         else if (port_acc && host_slot == SLOT_WIDTH'(s))
         begin
            if (idx_reg[s] == IDX_LAST)
               idx_reg[s] <= '0;
            else
               idx_reg[s] <= IDX_WIDTH'(idx_reg[s] + 7'h01);
         end
      end
   end

   // host write blocks any engine write in the same cycle; no reset on the array
   always_ff @(posedge clock)
   begin
      if (wr_take)
         buf_mem[mem_addr(host_slot, host_idx)] <= bus_wdata;
      // an engine index past the last entry would land in the next slot's buffer, a controller past the last beyond the array
      else if (eng_we && SLOT_WIDTH'(eng_ctrl) < SLOT_WIDTH'(NUM_CTRL)
         && eng_idx <= IDX_LAST)
         buf_mem[mem_addr({1'b0, eng_ctrl} << 1 | SLOT_WIDTH'(eng_buf),
            eng_idx)] <= eng_wdata;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         bus_rdata <= PORT_RESET;
         bus_rvalid <= 1'b0;
      end
      else
      begin
         bus_rvalid <= bus_rd;
         if (bus_rd)
         begin
            if (hit_sel)
               bus_rdata <= DATA_WIDTH'(sel_reg);
            else if (port_hit && readable)
               bus_rdata <= buf_mem[mem_addr(host_slot, host_idx)];
            else
               bus_rdata <= UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      eng_rdata <= buf_mem[mem_addr({1'b0, eng_ctrl} << 1
         | SLOT_WIDTH'(eng_buf), eng_idx)];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         tx_load_strobe <= 1'b0;
         tx_load_ctrl <= '0;
         tx_load_buf <= 1'b0;
         tx_load_len <= '0;
      end
      else
      begin
         tx_load_strobe <= wr_take;
         if (wr_take)
         begin
            tx_load_ctrl <= sel_reg;
            tx_load_buf <= host_buf;
            tx_load_len <= IDX_WIDTH'(host_idx + 7'h01);
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         rx_transfer_done_irq <= '0;
      else
         rx_transfer_done_irq <= rx_done;
   end

   // checks
   a_port_reset_zero: assert property (@(posedge clock)
      sys_rst |=> bus_rdata == PORT_RESET && !bus_rvalid && !tx_load_strobe)
      else $error("port not zero after reset");

   a_read_answer: assert property (@(posedge clock) disable iff (sys_rst)
      bus_rd ##1 !sys_rst |-> bus_rvalid)
      else $error("read not answered next cycle");

   a_index_step: assert property (@(posedge clock) disable iff (sys_rst)
      port_acc && !restart[host_slot] && host_idx != IDX_LAST
      |=> idx_reg[$past(host_slot)] == $past(host_idx) + 7'h01)
      else $error("index did not step");

   a_index_wrap: assert property (@(posedge clock) disable iff (sys_rst)
      port_acc && host_idx == IDX_LAST |=> idx_reg[$past(host_slot)] == 0)
      else $error("index did not wrap");

   a_tx_load_len: assert property (@(posedge clock) disable iff (sys_rst)
      wr_take |=> tx_load_strobe && tx_load_buf == $past(host_buf)
      && tx_load_len == $past(host_idx) + 7'h01)
      else $error("transmit load not reported");

   a_tx_refused: assert property (@(posedge clock) disable iff (sys_rst)
      bus_wr && port_hit && !writable |=> !tx_load_strobe)
      else $error("write to busy buffer taken");

   a_no_readback: assert property (@(posedge clock) disable iff (sys_rst)
      bus_rd && port_hit && !readable |=> bus_rdata == UNMAPPED_READ)
      else $error("unfilled buffer read back data");

   a_select_route: assert property (@(posedge clock) disable iff (sys_rst)
      bus_wr && hit_sel && bus_wdata < DATA_WIDTH'(NUM_CTRL)
      |=> sel_reg == $past(bus_wdata[SEL_WIDTH-1:0]))
      else $error("select write lost");

   a_irq_follows: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(rx_transfer_done_irq[0]) |-> $past(rx_done[0]))
      else $error("irq without receive completion");

   a_rx_restart: assert property (@(posedge clock) disable iff (sys_rst)
      rx_done[0] |=> idx_reg[$past(rx_filled_buffer_indicator[0])] == 0)
      else $error("receive index not restarted");

endmodule // hdlc_message_buffer_port

// [hdlc_engine_model.sv]
`timescale 1ns/1ns
module hdlc_engine_model
   import hdlc_buf_pkg::*;
#(
   parameter int unsigned NUM_CTRL = 3
)
(
   input wire logic clock,
   output logic [NUM_CTRL-1:0] tx_free_buffer_flag,
   output logic [NUM_CTRL-1:0] rx_filled_buffer_indicator,
   output logic [NUM_CTRL-1:0] rx_done,
   output logic eng_we,
   output logic [SEL_WIDTH-1:0] eng_ctrl,
   output logic eng_buf,
   output logic [IDX_WIDTH-1:0] eng_idx,
   output logic [DATA_WIDTH-1:0] eng_wdata
);
   initial
   begin
      {tx_free_buffer_flag, rx_filled_buffer_indicator, rx_done, eng_we} = '0;
      {eng_ctrl, eng_buf, eng_idx, eng_wdata} = '0;
   end
   // n of zero only repeats the completion, used to restart the read index
   task automatic fill(input logic [1:0] c, input logic b,
      input logic [7:0] salt, input int n);
      eng_ctrl = c;
      eng_buf = b;
      for (int i = 0; i < n; i++)
      begin
         @(negedge clock);
         eng_we = 1'b1;
         eng_idx = i[IDX_WIDTH-1:0];
         eng_wdata = i[7:0] ^ salt;
      end
      @(negedge clock);
      eng_we = 1'b0;
      // idle lines keep moving so stale data is never mistaken for valid
      eng_wdata = ~eng_wdata;
      rx_filled_buffer_indicator[c] = b;
      rx_done[c] = 1'b1;
      @(negedge clock);
      rx_done[c] = 1'b0;
   endtask
   // point the engine read port at one byte; data shows a cycle later
   task automatic peek(input logic [1:0] c, input logic b,
      input logic [6:0] i);
      @(negedge clock);
      eng_ctrl = c;
      eng_buf = b;
      eng_idx = i;
      @(negedge clock);
   endtask
   // toggling twice forces a fresh transmit message on buffer b
   task automatic set_free(input logic [1:0] c, input logic b);
      @(negedge clock);
      tx_free_buffer_flag[c] = ~b;
      @(negedge clock);
      tx_free_buffer_flag[c] = b;
   endtask
endmodule // hdlc_engine_model

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top
   import hdlc_buf_pkg::*;
;
   localparam int unsigned NC = 3;
   localparam int unsigned DEP = 96;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] bus_addr = '0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_wdata = '0;
   logic [7:0] bus_rdata, eng_wdata, eng_rdata, salt;
   logic bus_rvalid, tx_load_strobe, tx_load_buf, eng_we, eng_buf;
   logic [NC-1:0] tx_free_buffer_flag, rx_filled_buffer_indicator;
   logic [NC-1:0] rx_done, rx_transfer_done_irq;
   logic [1:0] tx_load_ctrl, eng_ctrl;
   logic [6:0] tx_load_len, eng_idx;
   logic [31:0] rng = 32'h628e456f;
   int num_errors = 0;
   int num_checks = 0;
   always #50 clock = ~clock;
   hdlc_message_buffer_port #(.NUM_CTRL(NC), .BUF_DEPTH(DEP)) DUT (
      .clock, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
      .bus_rvalid, .tx_free_buffer_flag, .rx_filled_buffer_indicator,
      .rx_done, .rx_transfer_done_irq, .tx_load_strobe, .tx_load_ctrl,
      .tx_load_buf, .tx_load_len, .eng_we, .eng_ctrl, .eng_buf, .eng_idx,
      .eng_wdata, .eng_rdata);
   hdlc_engine_model #(.NUM_CTRL(NC)) P (.clock, .tx_free_buffer_flag,
      .rx_filled_buffer_indicator, .rx_done, .eng_we, .eng_ctrl, .eng_buf,
      .eng_idx, .eng_wdata);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] rx_byte(input logic [7:0] s, input int i);
      return i[7:0] ^ s;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   // back-to-back reads, each answer checked on the following cycle
   task automatic rd_burst(input logic [11:0] a, input int n, input int first,
      input logic zero);
      logic [7:0] w;
      for (int i = 0; i <= n; i++)
      begin
         @(negedge clock);
         w = zero ? 8'h00 : rx_byte(salt, (first + i - 1) % DEP);
         if (i > 0)
            chk({bus_rvalid, bus_rdata}, {1'b1, w});
         bus_addr = a;
         bus_rd = (i < n);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clock);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clock);
      bus_wr = 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      test_done;
   end
   initial
   begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      chk(bus_rdata, 8'h00);
      rd_burst(BUF1_OFFSET, 1, 0, 1'b1);
      rd_burst(12'h200, 1, 0, 1'b1);
      for (int c = 0; c < NC; c++)
         for (int b = 0; b < 2; b++)
         begin
            salt = rng[7:0];
            rng = xs(rng);
            wr(SEL_OFFSET, c[7:0]);
            wr(SEL_OFFSET, 8'h03);
            @(negedge clock);
            bus_addr = SEL_OFFSET;
            bus_rd = 1'b1;
            @(negedge clock);
            bus_rd = 1'b0;
            chk({bus_rvalid, bus_rdata}, {1'b1, c[7:0]});
            P.fill(c[1:0], b[0], salt, DEP);
            chk(rx_transfer_done_irq, 16'(1) << c);
            rd_burst(b ? BUF1_OFFSET : BUF0_OFFSET, DEP + 1, 0, 1'b0);
            rd_burst(b ? BUF0_OFFSET : BUF1_OFFSET, 2, 0, 1'b1);
            rd_burst(b ? BUF1_OFFSET : BUF0_OFFSET, rng % 8 + 1, 1,
               1'b0);
            P.fill(c[1:0], b[0], salt, 0);
            rd_burst(b ? BUF1_OFFSET : BUF0_OFFSET, 2, 0, 1'b0);
            P.set_free(c[1:0], b[0]);
            for (int j = 1; j <= rng % 6 + 1; j++)
            begin
               wr(b ? BUF1_OFFSET : BUF0_OFFSET, 8'(xs(rng + j) >> 8));
               chk({tx_load_strobe, tx_load_ctrl, tx_load_buf, tx_load_len},
                  {1'b1, c[1:0], b[0], j[6:0]});
               P.peek(c[1:0], b[0], 7'(j - 1));
               chk(eng_rdata, 8'(xs(rng + j) >> 8));
            end
            wr(b ? BUF0_OFFSET : BUF1_OFFSET, rng[15:8]);
            chk(tx_load_strobe, 1'b0);
            rng = xs(rng);
            $display("test ctrl %0d buffer %0d done", c, b);
         end
      test_done;
   end
endmodule // tb_top
